// File: inc/perf_monitor_pkg.sv
// Constants, field layout and carrier types of the performance monitor.
// Assumes a single core clock domain; register numbers 0 to 3 index the port.
// How it works
// - Two 32-bit event tallies plus cycle tally.
// - Occurrence adds per pulse, duration per clock.
// - Overflow interrupts only when that counter enabled.
// - One overflow request to external interrupt controller.
// - Counters keep counting after overflow.
// - Registers 0-3 reachable only when privileged.
// - Cycle tally wraps to zero, sets flag.
// - Event tally wraps, sets bit 8 or 9.
// - Writing a tally presets its value.
// - Bits 27:20 select b, 19:12 select a.
// - Flags at bits 10, 9, 8.
// - Interrupt enables at bits 6, 5, 4.
// - Divider bit 3 gives one count per 64.
// - Bit 2 write one clears cycle tally.
// - Bit 1 write one clears event tallies.
// - Reset clears enable and interrupt enables.
// - Bit 0 is the global counting enable.
// - Request holds while enabled flag stays set.
package perf_monitor_pkg;

   // Register numbers on the coprocessor port
   localparam logic [1:0] REG_MONITOR_CONTROL = 2'h0;
   localparam logic [1:0] REG_CYCLE_TALLY = 2'h1;
   localparam logic [1:0] REG_EVENT_TALLY_A = 2'h2;
   localparam logic [1:0] REG_EVENT_TALLY_B = 2'h3;

   // Control field positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_EVENT_CLEAR = 1;
   localparam int BIT_CYCLE_CLEAR = 2;
   localparam int BIT_DIVIDER = 3;
   localparam int BIT_IEN_A = 4;
   localparam int BIT_IEN_B = 5;
   localparam int BIT_IEN_CYCLE = 6;
   localparam int BIT_FLAG_A = 8;
   localparam int BIT_FLAG_B = 9;
   localparam int BIT_FLAG_CYCLE = 10;
   localparam int SEL_A_LSB = 12;
   localparam int SEL_B_LSB = 20;
   localparam int SEL_WIDTH = 8;

   // Reset values of the defined control fields
   localparam logic RST_ENABLE = 1'b0;
   localparam logic [2:0] RST_IEN = 3'h0;
   localparam logic [2:0] RST_FLAGS = 3'h0;
   localparam logic RST_DIVIDER = 1'b0;
   localparam logic [7:0] RST_SELECT = 8'h00;
   localparam logic [31:0] RST_TALLY = 32'h0000_0000;

   // Prescaler: one cycle-tally count per 64 clocks
   localparam int PRESCALE_BITS = 6;
   localparam logic [5:0] RST_PRESCALE = 6'h00;

   // Coprocessor register request from the core
   typedef struct packed {
      logic valid;
      logic write;
      logic privileged;
      logic [1:0] number;
      logic [31:0] wdata;
   } cop_req_t;

   // Coprocessor answer back to the core
   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } cop_rsp_t;

endpackage

// File: rtl/performance_monitor_counters.sv
// Performance monitor: cycle tally, two event tallies, control register.
// Assumes the core issues register accesses on the same clock, and that
// the event inputs come from core logic on this clock.
`timescale 1ns/10ps
module performance_monitor_counters
   import perf_monitor_pkg::*;
#(
   parameter int NUM_EVENTS = 256 // Width of event bus, one per select code
) (
   input wire logic clock_i, // Core clock, 200 MHz
   input wire logic arst_n_i, // Async reset, active low
   input wire cop_req_t req_i, // Coprocessor register request
   input wire logic [NUM_EVENTS-1:0] events_i, // Event pulses or levels
   output cop_rsp_t rsp_o, // Read answer, one cycle later
   output logic access_fault_o, // Unprivileged access refused
   output logic overflow_irq_o // Single overflow request
);

   typedef struct packed {
      logic enable;
      logic divider;
      logic [2:0] ien; // {cycle, b, a}
      logic [2:0] flags; // {cycle, b, a}
      logic [7:0] sel_a;
      logic [7:0] sel_b;
      logic [5:0] prescale;
      logic cycle_clear;
      logic event_clear;
      cop_rsp_t rsp;
      logic fault;
      logic irq;
   } monitor_state_t;

   monitor_state_t state_reg;
   monitor_state_t state_next;

   logic access_ok;
   logic write_ctrl;
   logic write_cycle;
   logic write_a;
   logic write_b;
   logic cycle_count;
   logic event_a;
   logic event_b;
   logic [31:0] cycle_value;
   logic [31:0] value_a;
   logic [31:0] value_b;
   logic cycle_wrap;
   logic wrap_a;
   logic wrap_b;
   logic [2:0] wraps;
   logic [31:0] ctrl_view;

   // Privileged accesses only; others are refused and change nothing
   assign access_ok = req_i.valid && req_i.privileged;
   assign write_ctrl = access_ok && req_i.write && (req_i.number == REG_MONITOR_CONTROL);
   assign write_cycle = access_ok && req_i.write && (req_i.number == REG_CYCLE_TALLY);
   assign write_a = access_ok && req_i.write && (req_i.number == REG_EVENT_TALLY_A);
   assign write_b = access_ok && req_i.write && (req_i.number == REG_EVENT_TALLY_B);

   // Prescaler wraps every 64 clocks; it runs free so the phase is unknown
   // to software, at most 63 clocks of skew on the first divided count
   assign cycle_count = state_reg.enable &&
      (!state_reg.divider || (&state_reg.prescale));

   // Pulse inputs count once per pulse, levels once per clock they hold
   assign event_a = state_reg.enable && events_i[state_reg.sel_a];
   assign event_b = state_reg.enable && events_i[state_reg.sel_b];

   tally_counter #(
      .WIDTH(32)
   ) u_cycle (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .count_i(cycle_count),
      .clear_i(state_reg.cycle_clear),
      .load_i(write_cycle),
      .load_value_i(req_i.wdata),
      .value_o(cycle_value),
      .wrap_o(cycle_wrap)
   );

   tally_counter #(
      .WIDTH(32)
   ) u_event_a (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .count_i(event_a),
      .clear_i(state_reg.event_clear),
      .load_i(write_a),
      .load_value_i(req_i.wdata),
      .value_o(value_a),
      .wrap_o(wrap_a)
   );

   tally_counter #(
      .WIDTH(32)
   ) u_event_b (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .count_i(event_b),
      .clear_i(state_reg.event_clear),
      .load_i(write_b),
      .load_value_i(req_i.wdata),
      .value_o(value_b),
      .wrap_o(wrap_b)
   );

   assign wraps = {cycle_wrap, wrap_b, wrap_a};

   // Control register read view; clear bits and reserved bits read zero
   always_comb begin
      ctrl_view = '0;
      ctrl_view[BIT_ENABLE] = state_reg.enable;
      ctrl_view[BIT_DIVIDER] = state_reg.divider;
      ctrl_view[BIT_IEN_A] = state_reg.ien[0];
      ctrl_view[BIT_IEN_B] = state_reg.ien[1];
      ctrl_view[BIT_IEN_CYCLE] = state_reg.ien[2];
      ctrl_view[BIT_FLAG_A] = state_reg.flags[0];
      ctrl_view[BIT_FLAG_B] = state_reg.flags[1];
      ctrl_view[BIT_FLAG_CYCLE] = state_reg.flags[2];
      ctrl_view[SEL_A_LSB +: SEL_WIDTH] = state_reg.sel_a;
      ctrl_view[SEL_B_LSB +: SEL_WIDTH] = state_reg.sel_b;
   end

   // Next-state logic for control, flags, prescaler, answer and request
   always_comb begin
      state_next = state_reg;
      state_next.prescale = state_reg.prescale + 1'b1;
      state_next.cycle_clear = 1'b0;
      state_next.event_clear = 1'b0;
      state_next.rsp = '0;
      state_next.fault = req_i.valid && !req_i.privileged;
      if (write_ctrl) begin
         state_next.enable = req_i.wdata[BIT_ENABLE];
         state_next.divider = req_i.wdata[BIT_DIVIDER];
         state_next.ien = {req_i.wdata[BIT_IEN_CYCLE], req_i.wdata[BIT_IEN_B],
                           req_i.wdata[BIT_IEN_A]};
         state_next.sel_a = req_i.wdata[SEL_A_LSB +: SEL_WIDTH];
         state_next.sel_b = req_i.wdata[SEL_B_LSB +: SEL_WIDTH];
         state_next.cycle_clear = req_i.wdata[BIT_CYCLE_CLEAR];
         state_next.event_clear = req_i.wdata[BIT_EVENT_CLEAR];
         // Write one clears a flag, zero leaves it
         state_next.flags = state_reg.flags & ~{req_i.wdata[BIT_FLAG_CYCLE],
            req_i.wdata[BIT_FLAG_B], req_i.wdata[BIT_FLAG_A]};
      end
      // A wrap in the same cycle as a clear still sets the flag
      state_next.flags = state_next.flags | wraps;
      if (access_ok && !req_i.write) begin
         state_next.rsp.valid = 1'b1;
         unique case (req_i.number)
            REG_MONITOR_CONTROL: state_next.rsp.rdata = ctrl_view;
            REG_CYCLE_TALLY: state_next.rsp.rdata = cycle_value;
            REG_EVENT_TALLY_A: state_next.rsp.rdata = value_a;
            REG_EVENT_TALLY_B: state_next.rsp.rdata = value_b;
         endcase
      end
      // Level request from registered flags, held until the flags or their enables are cleared
      state_next.irq = |(state_next.flags & state_next.ien);
   end

   // Reset clears enable and interrupt enables; the rest is made zero too
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= '0;
         state_reg.enable <= RST_ENABLE;
         state_reg.ien <= RST_IEN;
         state_reg.flags <= RST_FLAGS;
         state_reg.divider <= RST_DIVIDER;
         state_reg.sel_a <= RST_SELECT;
         state_reg.sel_b <= RST_SELECT;
         state_reg.prescale <= RST_PRESCALE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rsp_o = state_reg.rsp;
   assign access_fault_o = state_reg.fault;
   assign overflow_irq_o = state_reg.irq;

endmodule

// File: rtl/tally_counter.sv
// One 32-bit tally with software preset, clear and wrap detection.
// Assumes the count strobe is already a same-clock single-cycle qualifier.
`timescale 1ns/10ps
module tally_counter
   import perf_monitor_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic clock_i, // Core clock
   input wire logic arst_n_i, // Async reset, active low
   input wire logic count_i, // Add one this cycle
   input wire logic clear_i, // Force to zero
   input wire logic load_i, // Load preset value
   input wire logic [WIDTH-1:0] load_value_i, // Preset value
   output logic [WIDTH-1:0] value_o, // Current tally
   output logic wrap_o // Wrapped this cycle
);

   typedef struct packed {
      logic [WIDTH-1:0] value;
      logic wrap;
   } tally_state_t;

   tally_state_t state_reg;
   tally_state_t state_next;

   // Software write beats clear and count; counting never stops on overflow
   always_comb begin
      state_next = state_reg;
      state_next.wrap = 1'b0;
      if (load_i) begin
         state_next.value = load_value_i;
      end else if (clear_i) begin
         state_next.value = '0;
      end else if (count_i) begin
         state_next.value = state_reg.value + 1'b1;
         state_next.wrap = &state_reg.value;
      end
   end

   // Counter values are arbitrary after reset; zero is a clean choice
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign value_o = state_reg.value;
   assign wrap_o = state_reg.wrap;

endmodule

// File: verification/core_model.sv
// Processor core model issuing coprocessor register accesses.
// Assumes the monitor takes a request at the edge it sees it valid.
`timescale 1ns/10ps
module core_model
   import perf_monitor_pkg::*;
(
   input wire logic clock_i, // Core clock
   input wire cop_rsp_t rsp_i, // Answer
   output cop_req_t req_o // Request
);
   initial req_o = '0;
   // Drive after an edge, taken at the next; the answer stands in the following cycle
   task automatic xfer(input logic wr, input logic pr, input logic [1:0] num,
         input logic [31:0] wd, output logic [31:0] rd, output logic ok);
      @(posedge clock_i);
      #1 req_o = '{1'b1, wr, pr, num, wd};
      @(posedge clock_i);
      #1 req_o.valid = 1'b0;
      req_o.wdata = ~wd; // Released data must not look held
      ok = rsp_i.valid;
      rd = rsp_i.rdata;
   endtask
endmodule

// File: verification/perf_monitor_checker.sv
// Port checks for the performance monitor.
// Assumes it is bound to the monitor top on the core clock.
`timescale 1ns/10ps
module perf_monitor_checker
   import perf_monitor_pkg::*;
#(
   parameter int NUM_EVENTS = 256
) (
   input wire logic clock_i, // Core clock
   input wire logic arst_n_i, // Async reset
   input wire cop_req_t req_i, // Request
   input wire logic [NUM_EVENTS-1:0] events_i, // Event bus
   input wire cop_rsp_t rsp_o, // Answer
   input wire logic access_fault_o, // Refusal pulse
   input wire logic overflow_irq_o // Overflow request
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   // Request classes
   wire logic rd_ok = req_i.valid && !req_i.write && req_i.privileged;
   wire logic bad = req_i.valid && !req_i.privileged;
   wire logic cw = req_i.valid && req_i.write && req_i.privileged && req_i.number == 2'h0;
   read_answer_a: assert property (rd_ok |=> rsp_o.valid) else $error("no answer");
   answer_cause_a: assert property (rsp_o.valid |-> $past(rd_ok)) else $error("stray answer");
   fault_pulse_a: assert property (bad |=> access_fault_o && !rsp_o.valid) else $error("no fault");
   fault_cause_a: assert property (access_fault_o |-> $past(bad)) else $error("stray fault");
   write_quiet_a: assert property (req_i.valid && req_i.write |=> !rsp_o.valid) else $error("w ans");
   reserved_zero_a: assert property (rd_ok && req_i.number == 2'h0 |=>
      (rsp_o.rdata & 32'hf000_0886) == 32'h0) else $error("reserved bits set");
   irq_masked_a: assert property (cw && req_i.wdata[6:4] == 3'h0 ##1 !cw |=>
      !overflow_irq_o) else $error("masked irq high");
   irq_hold_a: assert property ($fell(overflow_irq_o) |-> $past(cw)) else $error("irq drop");
   // Main scenarios reached
   cover property (rd_ok ##1 rsp_o.valid);
   cover property (access_fault_o);
   cover property ($rose(overflow_irq_o));
endmodule
bind performance_monitor_counters perf_monitor_checker #(.NUM_EVENTS(NUM_EVENTS)) chk_u (
   .clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req_i), .events_i(events_i),
   .rsp_o(rsp_o), .access_fault_o(access_fault_o), .overflow_irq_o(overflow_irq_o));

// File: verification/performance_monitor_counters_tb.sv
// Self-checking bench with a reference model of the monitor.
// Assumes the core model issues all accesses; events run randomly.
`timescale 1ns/10ps
module performance_monitor_counters_tb;
   import perf_monitor_pkg::*;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [255:0] events_i = '0;
   cop_req_t req_i;
   cop_rsp_t rsp_o;
   logic access_fault_o, overflow_irq_o, ok, en, dv;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   integer seed = 32'h06dd3361;
   logic [32:0] cyc, ea, eb;
   logic [31:0] rd, w;
   logic [7:0] sa, sb;
   logic [5:0] psc;
   logic [2:0] flg, ien, pend, nw;
   always #2.5 clock_i = ~clock_i;
   performance_monitor_counters #(.NUM_EVENTS(256)) dut_u (.clock_i(clock_i),
      .arst_n_i(arst_n_i), .req_i(req_i), .events_i(events_i), .rsp_o(rsp_o),
      .access_fault_o(access_fault_o), .overflow_irq_o(overflow_irq_o));
   core_model core_u (.clock_i(clock_i), .rsp_i(rsp_o), .req_o(req_i));
   // Random pulses and levels, moved just after each edge
   always @(posedge clock_i) begin
      #1;
      for (int k = 0; k < 8; k++) events_i[k*32 +: 32] = $random(seed);
   end
   // Model counts with the state before the edge, then takes the request
   always @(posedge clock_i) begin
      cycles++;
      if (cycles > 5000) begin
         failures++;
         stop_test();
      end
      if (!arst_n_i) begin
         {psc, en, dv, ien, flg, pend, sa, sb} = '0;
         {cyc, ea, eb} = '0;
      end else begin
         if (en && (!dv || psc == 6'h3f)) cyc = cyc + 1;
         if (en) ea = ea + events_i[sa];
         if (en) eb = eb + events_i[sb];
         nw = {cyc[32], eb[32], ea[32]};
         {cyc[32], eb[32], ea[32]} = 3'h0;
         psc = psc + 6'h1;
         if (req_i.valid && req_i.write && req_i.privileged) begin
            case (req_i.number)
               2'h0: begin
                  {sb, sa, flg} = {req_i.wdata[27:12], flg & ~req_i.wdata[10:8]};
                  {ien, dv, en} = {req_i.wdata[6:3], req_i.wdata[0]};
                  if (req_i.wdata[2]) cyc = '0;
                  if (req_i.wdata[1]) {ea, eb} = '0;
               end
               2'h1: cyc = {1'b0, req_i.wdata};
               2'h2: ea = {1'b0, req_i.wdata};
               default: eb = {1'b0, req_i.wdata};
            endcase
         end
         // A wrap reaches the flags one edge later and beats a same-edge clear
         flg = flg | pend;
         pend = nw;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, want, seen);
      end
   endtask
   // Read every register with counting stopped, then the request line
   task automatic rdall();
      logic [31:0] want [4];
      want = '{{4'h0, sb, sa, 1'b0, flg, 1'b0, ien, dv, 2'b00, en}, cyc[31:0], ea[31:0], eb[31:0]};
      for (int n = 0; n < 4; n++) begin
         core_u.xfer(1'b0, 1'b1, 2'(n), 32'h0, rd, ok);
         check("answer", {31'h0, ok}, 32'h1);
         check("fault", {31'h0, access_fault_o}, 32'h0);
         check("register", rd, want[n]);
      end
      check("irq", {31'h0, overflow_irq_o}, {31'h0, |(flg & ien)});
   endtask
   task automatic stop_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Reset, refusal, overflow runs in both divider modes, flag and tally clears
   initial begin
      repeat (8) @(posedge clock_i);
      #1 arst_n_i = 1'b1;
      rdall();
      core_u.xfer(1'b1, 1'b0, 2'h1, 32'hffff_ffff, rd, ok);
      check("fault", {31'h0, access_fault_o}, 32'h1);
      check("refused", {31'h0, ok}, 32'h0);
      rdall();
      for (int r = 0; r < 2; r++) begin
         for (int n = 1; n < 4; n++) core_u.xfer(1'b1, 1'b1, 2'(n), 32'hffff_fff0 | $random(seed), rd, ok);
         w = ($random(seed) & 32'h0fff_f000) | 32'h71 | (r << 3);
         core_u.xfer(1'b1, 1'b1, 2'h0, w, rd, ok);
         repeat (60 + r * 1100) @(posedge clock_i);
         core_u.xfer(1'b1, 1'b1, 2'h0, w & 32'hffff_fffe, rd, ok);
         rdall();
      end
      core_u.xfer(1'b1, 1'b1, 2'h0, 32'h0000_0170, rd, ok);
      rdall();
      core_u.xfer(1'b1, 1'b1, 2'h0, 32'h0000_0776, rd, ok);
      rdall();
      core_u.xfer(1'b1, 1'b1, 2'h0, 32'h0, rd, ok);
      rdall();
      stop_test();
   end
endmodule
